/* File: sfr_rx_formatter.sv */
`timescale 1ns/1ps
`include "sfr_map.svh"
// Overview of operation
// - phase one word length from code
// - phase two length used in dual phase
// - word count field is words minus one
// - frame words: phase one, or both sums
// - sync before frame end is unexpected
// - ignore bit set: keep receiving unaffected
// - ignore clear: abort word, flag, restart
// - new word starts after data delay
// - companding expands to left-justified 16 bits
// - justification ignored while expanding
// - expansion forces eight bit words
// - data option decodes four modes
// - option one reverses eight bit words
// - frame starts at first active sync
// - delay codes give 0,1,2,3 clocks
// - zero delay samples on sync edge
// - two delay skips the framing bit
// - phase select: 0 single, 1 dual
// - justify codes place data in registers
// - data sampled on falling receive clock
// - sync error raises irq in mode 11
module sfr_rx_formatter (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_clock_pin,
   input  wire logic        rx_sync_pin,
   input  wire logic        rx_data_pin,
   output logic             rx_irq
);
   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // a reserved code still frames, so a bad setting cannot hang the receiver
   // word length code to bits
   function automatic logic [5:0] len_bits(input logic [2:0] c);
      case (c)
         3'h0:    len_bits = `SFR_WL_8;
         3'h1:    len_bits = `SFR_WL_12;
         3'h2:    len_bits = `SFR_WL_16;
         3'h3:    len_bits = `SFR_WL_20;
         3'h4:    len_bits = `SFR_WL_24;
         3'h5:    len_bits = `SFR_WL_32;
         default: len_bits = `SFR_WL_8;         // reserved codes act as 8 bits
      endcase
   endfunction

   // the bias is added before the segment shift and removed after it,
   // which gives the usual segment end points without a lookup table
   // mu-law code to 16-bit two's complement
   function automatic logic [15:0] mu_exp(input logic [7:0] c);
      logic [7:0]  u;
      logic [15:0] t;
      u = ~c;
      t = (16'({u[3:0], 3'h0}) + 16'h0084) << u[6:4];
      t = t - 16'h0084;
      mu_exp = u[7] ? 16'(~t + 16'h0001) : t;
   endfunction

   // alternate bits travel inverted on the line, hence the xor with 0x55;
   // segment zero has no implied leading one
   // a-law code to 16-bit two's complement
   function automatic logic [15:0] a_exp(input logic [7:0] c);
      logic [7:0]  a;
      logic [15:0] t;
      a = c ^ 8'h55;
      t = {8'h00, a[3:0], 4'h8};
      if (a[6:4] != 3'h0) begin
         t = (t + 16'h0100) << 3'(a[6:4] - 3'h1);
      end
      a_exp = a[7] ? t : 16'(~t + 16'h0001);
   endfunction

   // expansion always yields a left-justified 16-bit value and ignores the
   // justify field; lsb-first words are reversed before justification;
   // justify code 11 falls back to right-justified with zero fill
   // buffered word to {high, low} data register image
   function automatic logic [31:0] fmt(input logic [31:0] w, input logic [5:0] n,
                                       input logic [1:0] opt, input logic [1:0] j);
      logic [31:0] m;
      logic [31:0] v;
      logic [7:0]  r;
      m = (n == `SFR_WL_32) ? 32'hffffffff : ((32'h1 << n) - 32'h1);
      for (int i = 0; i < 8; i++) begin
         r[i] = w[7 - i];
      end
      v = w & m;
      fmt = v;
      case (opt)
         2'h2: fmt = {16'h0000, mu_exp(w[7:0])};
         2'h3: fmt = {16'h0000, a_exp(w[7:0])};
         default: begin
            if (opt == 2'h1) begin
               v = {24'h000000, r};
            end
            case (j)
               2'h1: fmt = |(v & (32'h1 << 6'(n - 6'd1))) ? (v | ~m) : v;
               2'h2: fmt = v << 6'(`SFR_WL_32 - n);
               default: fmt = v;
            endcase
         end
      endcase
   endfunction

   // ----------------------------------------------------------------
   // state and derived values
   // ----------------------------------------------------------------
   sfr_pkg::sfr_state_s_t q;       // registered state
   sfr_pkg::sfr_state_s_t d;       // next state

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   // one pass computes everything from q; later sections override earlier
   // ones, which is how a hardware set beats a software clear on the
   // sync error and ready flags
   // bus slave, buffer move, receive sequencer in priority order
   always_comb begin
      logic        fall;
      logic        fs_start;
      logic        take;
      logic        restart;
      logic        dual;
      logic        ph2;
      logic [1:0]  opt;
      logic [5:0]  wl;
      logic [5:0]  bc;
      logic [8:0]  wi;
      logic [8:0]  total;
      logic [31:0] ns;
      logic [31:0] img;
      d        = q;
      fall     = 1'b0;
      fs_start = 1'b0;
      take     = 1'b0;
      restart  = 1'b0;
      dual     = q.ctl2[`SFR_DUAL_BIT];
      opt      = q.ctl2[`SFR_OPT_HI:`SFR_OPT_LO];
      ph2      = 1'b0;
      wl       = `SFR_WL_8;
      bc       = q.bitcnt;
      wi       = q.widx;
      total    = 9'd0;
      ns       = 32'h0;
      img      = 32'h0;
      d.irq     = 1'b0;
      d.pready  = 1'b0;
      d.pslverr = 1'b0;

      // clk_p is only edge history: data and sync have the same depth as
      // clk_s, so all three pins stay aligned at the detected fall
      // pin synchronisers, two flops each
      d.clk_m = rx_clock_pin;
      d.clk_s = q.clk_m;
      d.clk_p = q.clk_s;
      d.fs_m  = rx_sync_pin;
      d.fs_s  = q.fs_m;
      d.dat_m = rx_data_pin;
      d.dat_s = q.dat_m;

      // the answer is prepared one cycle early so that pready and prdata
      // come from flops and the access phase never waits
      // setup phase: decode and prepare answer for the access phase
      if (psel && !penable) begin
         d.pready = 1'b1;
         d.prdata = 32'h0;
         unique case (paddr)
            `SFR_OFF_CTL1:      d.prdata = {16'h0000, q.ctl1};
            `SFR_OFF_CTL2:      d.prdata = {16'h0000, q.ctl2};
            `SFR_OFF_SCTL1: begin
               d.prdata[`SFR_JUST_HI:`SFR_JUST_LO] = q.justify;
               d.prdata[`SFR_IRQM_HI:`SFR_IRQM_LO] = q.irq_mode;
               d.prdata[`SFR_ERR_BIT]              = q.err;
               d.prdata[`SFR_RDY_BIT]              = q.rdy;
               d.prdata[`SFR_EN_BIT]               = q.rx_en;
            end
            `SFR_OFF_DATA_LOW:  d.prdata = {16'h0000, q.data_low};
            `SFR_OFF_DATA_HIGH: d.prdata = {16'h0000, q.data_high};
            default:            d.pslverr = 1'b1;   // unmapped address
         endcase
      end

      // a refused access changes no register
      // access phase completes this edge: writes and read side effects
      if (psel && penable && q.pready && !q.pslverr) begin
         if (pwrite) begin
            unique case (paddr)
               `SFR_OFF_CTL1: d.ctl1 = {1'b0, pwdata[14:0]};
               `SFR_OFF_CTL2: d.ctl2 = pwdata[15:0];
               `SFR_OFF_SCTL1: begin
                  d.justify  = pwdata[`SFR_JUST_HI:`SFR_JUST_LO];
                  d.irq_mode = pwdata[`SFR_IRQM_HI:`SFR_IRQM_LO];
                  d.rx_en    = pwdata[`SFR_EN_BIT];
                  if (!pwdata[`SFR_ERR_BIT]) begin
                     d.err = 1'b0;              // writing zero clears the flag
                  end
               end
               default: ;                       // data registers are read only
            endcase
         end else if (paddr == `SFR_OFF_DATA_LOW) begin
            d.rdy = 1'b0;                       // reading low word consumes it
         end
      end

      // the buffer empties the cycle after it fills; a link bit lasts at
      // least eight core cycles, so the next word cannot overrun it
      // move buffered word into the data registers
      if (q.rbr_full) begin
         img         = fmt(q.rbr, q.rbr_len, opt, q.justify);
         d.data_low  = img[15:0];
         d.data_high = img[31:16];
         d.rbr_full  = 1'b0;
         d.rdy       = 1'b1;
         if (q.irq_mode == 2'h0 && !q.rdy) begin
            d.irq = 1'b1;                       // ready rising in mode 00
         end
      end

      // a sync that is still high from the last frame does not restart it
      // falling edge of receive clock, sync rising as sampled then
      fall     = q.clk_p && !q.clk_s;
      fs_start = fall && q.fs_s && !q.fs_last;

      // disabled: the sequencer parks in idle and the sync history freezes,
      // so the first frame after enable needs a fresh sync rise
      if (!q.rx_en) begin
         d.st = sfr_pkg::ST_IDLE;               // receiver held in reset
      end else if (fall) begin
         d.fs_last = q.fs_s;
         if (fs_start && (q.st == sfr_pkg::ST_IDLE ||
                          !q.ctl2[`SFR_IGN_BIT])) begin
            if (q.st != sfr_pkg::ST_IDLE) begin
               d.err = 1'b1;
            end
            restart = 1'b1;                     // interrupted word is dropped
            bc      = 6'd0;
            wi      = 9'd0;
            d.shift = 32'h0;
            d.bitcnt = 6'd0;                    // no stale count survives a delay
            d.widx   = 9'd0;
            // delay zero takes the sync slot itself as the first data bit
            unique case (q.ctl2[`SFR_DLY_HI:`SFR_DLY_LO])
               2'h0: begin
                  d.st = sfr_pkg::ST_SHIFT;
                  take = 1'b1;
               end
               default: begin
                  d.st  = sfr_pkg::ST_DELAY;
                  d.dly = q.ctl2[`SFR_DLY_HI:`SFR_DLY_LO];
               end
            endcase
         end else begin
            unique case (q.st)
               sfr_pkg::ST_IDLE: ;
               sfr_pkg::ST_DELAY: begin
                  d.dly = 2'(q.dly - 2'h1);
                  if (q.dly == 2'h1) begin
                     // the last delay edge already carries the first data bit
                     d.st = sfr_pkg::ST_SHIFT;
                     take = 1'b1;
                  end
               end
               sfr_pkg::ST_SHIFT: take = 1'b1;
               default: d.st = sfr_pkg::ST_IDLE;
            endcase
         end
      end

      // phase two starts once the word index passes the phase one count;
      // the frame ends when the index reaches the total
      // take one data bit into the shift register
      if (take) begin
         total = 9'({2'b00, q.ctl1[`SFR_CNT_HI:`SFR_CNT_LO]} + 9'd1);
         if (dual) begin
            total = 9'(total + {2'b00, q.ctl2[`SFR_CNT_HI:`SFR_CNT_LO]} + 9'd1);
         end
         ph2 = dual && (wi > {2'b00, q.ctl1[`SFR_CNT_HI:`SFR_CNT_LO]});
         if (opt != 2'h0) begin
            wl = `SFR_WL_8;
         end else if (ph2) begin
            wl = len_bits(q.ctl2[`SFR_LEN_HI:`SFR_LEN_LO]);
         end else begin
            wl = len_bits(q.ctl1[`SFR_LEN_HI:`SFR_LEN_LO]);
         end
         // a restart on this edge starts from an empty shift register
         ns      = {(restart ? 31'h0 : q.shift[30:0]), q.dat_s};
         d.shift = ns;
         if (6'(bc + 6'd1) == wl) begin
            d.rbr      = ns;
            d.rbr_len  = wl;
            d.rbr_full = 1'b1;
            d.bitcnt   = 6'd0;
            d.widx     = 9'(wi + 9'd1);
            if (9'(wi + 9'd1) == total) begin
               d.st = sfr_pkg::ST_IDLE;
            end
         end else begin
            d.bitcnt = 6'(bc + 6'd1);
            d.widx   = wi;
         end
      end

      // pulse only when the flag goes from clear to set
      // sync error interrupt in mode 11
      if (q.irq_mode == 2'h3 && d.err && !q.err) begin
         d.irq = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // the whole state is one struct, so no field can be missed here
   // asynchronous reset to constants only
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q      <= '0;
         q.st   <= sfr_pkg::ST_IDLE;
         q.ctl1 <= `SFR_CTL_RESET;
         q.ctl2 <= `SFR_CTL_RESET;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flops
   // ----------------------------------------------------------------
   assign prdata  = q.prdata;
   assign pready  = q.pready;
   assign pslverr = q.pslverr;
   assign rx_irq  = q.irq;
endmodule // sfr_rx_formatter

/* File: sfr_map.svh */
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SFR_OFF_CTL1       8'h00
`define SFR_OFF_CTL2       8'h04
`define SFR_OFF_SCTL1      8'h08
`define SFR_OFF_DATA_LOW   8'h0c
`define SFR_OFF_DATA_HIGH  8'h10
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SFR_CNT_HI        14
`define SFR_CNT_LO        8
`define SFR_LEN_HI        7
`define SFR_LEN_LO        5
`define SFR_DUAL_BIT      15
`define SFR_OPT_HI        4
`define SFR_OPT_LO        3
`define SFR_IGN_BIT       2
`define SFR_DLY_HI        1
`define SFR_DLY_LO        0
`define SFR_EN_BIT        0
`define SFR_RDY_BIT       1
`define SFR_ERR_BIT       3
`define SFR_IRQM_HI       5
`define SFR_IRQM_LO       4
`define SFR_JUST_HI       14
`define SFR_JUST_LO       13
// ----------------------------------------------------------------
// word lengths per code, and reset values
// ----------------------------------------------------------------
`define SFR_WL_8          6'd8
`define SFR_WL_12         6'd12
`define SFR_WL_16         6'd16
`define SFR_WL_20         6'd20
`define SFR_WL_24         6'd24
`define SFR_WL_32         6'd32
`define SFR_CTL_RESET     16'h0000
`endif

/* File: sfr_pkg.sv */
package sfr_pkg;
   // receiver sequencing states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_DELAY = 3'b010,
      ST_SHIFT = 3'b100
   } sfr_state_t;

   // the whole state of the formatter
   typedef struct packed {
      logic       clk_m, clk_s, clk_p;   // clock pin synchroniser and history
      logic       fs_m, fs_s, fs_last;   // sync pin synchroniser, last sampled sync
      logic       dat_m, dat_s;          // data pin synchroniser
      logic [15:0] ctl1, ctl2;           // receive control words
      logic       rx_en;                 // receiver enable
      logic [1:0] irq_mode, justify;     // interrupt mode, justification mode
      logic       err, rdy;              // sync error, data ready
      logic [15:0] data_low, data_high;  // data receive registers
      logic [31:0] rbr;                  // receive buffer
      logic [5:0] rbr_len;               // length of buffered word
      logic       rbr_full;              // buffer waiting for move
      logic [31:0] shift;                // shift register
      logic [5:0] bitcnt;                // bits taken in current word
      logic [8:0] widx;                  // word index in frame
      logic [1:0] dly;                   // remaining data delay
      sfr_state_t st;                    // sequencer state
      logic [31:0] prdata;               // bus read data
      logic       pready, pslverr;       // bus answer
      logic       irq;                   // interrupt pulse
   } sfr_state_s_t;
endpackage

/* File: sfr_rx_formatter_asserts.sv */
`timescale 1ns/1ps
// ----
// bus answer and irq checks
// ----
module sfr_rx_checker (
   input wire logic        core_clk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rx_clock_pin,
   input wire logic        rx_irq
);
   logic [3:0] age_q;  // cycles since the link clock last fell
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // saturating age counter of the last link clock fall
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         age_q <= 4'hf;
      end else if ($fell(rx_clock_pin)) begin
         age_q <= 4'h0;
      end else if (age_q != 4'hf) begin
         age_q <= age_q + 4'h1;
      end
   end
   bus_answer_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   answer_cause_a: assert property (pready |-> $past(psel && !penable))
      else $error("answer without setup");
   answer_pulse_a: assert property (pready |=> !pready)
      else $error("answer held too long");
   err_unmapped_a: assert property (psel && !penable && paddr > 8'h10 |=> pslverr)
      else $error("unmapped address accepted");
   err_mapped_a: assert property (
      psel && !penable && paddr[1:0] == 2'h0 && paddr <= 8'h10 |=> !pslverr)
      else $error("mapped address refused");
   err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("refusal with data or without answer");
   irq_pulse_a: assert property (rx_irq |=> !rx_irq)
      else $error("irq longer than one cycle");
   irq_cause_a: assert property (rx_irq |-> age_q < 4'hc)
      else $error("irq without link activity");
endmodule // sfr_rx_checker
bind sfr_rx_formatter sfr_rx_checker chk (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rx_clock_pin(rx_clock_pin), .rx_irq(rx_irq));

/* File: sfr_codec_model.sv */
`timescale 1ns/1ps
// ----
// serial peer: 160 ns bit clock, only within frames
// ----
module sfr_codec_model (
   input  wire logic core_clk,
   output logic      rx_clock_pin,
   output logic      rx_sync_pin,
   output logic      rx_data_pin
);
   initial begin
      rx_clock_pin = 1'b0;
      rx_sync_pin  = 1'b0;
      rx_data_pin  = 1'b0;
   end
   // slot 0 and slot p carry sync; bits sent msb of stream first
   task automatic send(input logic [127:0] s, input int n, input int p);
      // four core cycles high, four low: a 160 ns bit clock
      for (int i = 0; i < n; i++) begin
         rx_sync_pin  <= (i == 0 || i == p);
         rx_data_pin  <= s[n-1-i];
         rx_clock_pin <= 1'b1;
         repeat (4) @(posedge core_clk);
         rx_clock_pin <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
      rx_sync_pin <= 1'b0;
      rx_data_pin <= ~rx_data_pin;  // released line shows no stale bit
   endtask
endmodule // sfr_codec_model

/* File: test_sfr_rx_formatter.sv */
`timescale 1ns/1ps
// ----
// receive formatter bench
// ----
module test_sfr_rx_formatter;
   logic        core_clk, rst_b, psel, penable, pwrite, er, pready, pslverr, rx_irq, ck, fs, dt;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, v, ex;
   logic [39:0] f;  // dual phase frame: 8, 16, 16 bits
   int          fails, samples_checked, irq_n, ln, d;
   sfr_rx_formatter uut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_clock_pin(ck), .rx_sync_pin(fs), .rx_data_pin(dt), .rx_irq(rx_irq));
   sfr_codec_model peer (.core_clk(core_clk), .rx_clock_pin(ck), .rx_sync_pin(fs),
      .rx_data_pin(dt));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // count irq pulses
   always @(posedge core_clk) begin
      if (rx_irq === 1'b1) irq_n++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // one transfer, entered just after a rising edge; held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      // pready, prdata and pslverr are taken at the rising edge itself
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
         summarize();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rdk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd, e);
   endtask
   // configure, send a stream, then read high and low data words
   task automatic word(input logic [31:0] c1, c2, s1, input logic [127:0] s, input int n, p,
                       input logic [31:0] lo, hi);
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h00, c1);
      apb(1'b1, 8'h04, c2);
      apb(1'b1, 8'h08, s1);
      irq_n = 0;
      peer.send(s, n, p);
      repeat (12) @(posedge core_clk);
      rdk(8'h10, hi);
      rdk(8'h0c, lo);
   endtask
   initial begin
      rst_b   = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      fails = 0;
      samples_checked = 0;
      irq_n = 0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      // reset values, refused address, upper bits dropped
      for (int a = 0; a < 20; a += 4) rdk(8'(a), 32'h0);
      rdk(8'h14, 32'h0);
      check({31'h0, er}, 32'h1);
      apb(1'b1, 8'h04, 32'hffffffff);
      rdk(8'h04, 32'h0000ffff);
      $display("registers done");
      // every length code, justify codes 0 to 2 and delays 0 to 2
      for (int c = 0; c < 8; c++) begin
         for (int j = 0; j < 3; j++) begin
            ln = (c > 5) ? 8 : (c == 5) ? 32 : 8 + 4 * c;
            d  = (c + j) % 3;
            v  = 32'habcdef12 >> (32 - ln);
            ex = (j == 2) ? v << (32 - ln) : v;
            if (j == 1) ex = ex | ~32'((33'h1 << ln) - 33'h1);
            word(32'(c) << 5, 32'(d), 32'(j) << 13 | 32'h1,
                 128'(v) | (d == 2 ? 128'h1 << ln : 128'h0), ln + d, 0,
                 32'(ex[15:0]), 32'(ex[31:16]));
            rdk(8'h08, 32'(j) << 13 | 32'h1);
            check(irq_n, 1);
         end
      end
      $display("lengths done");
      // reversal and expansion, with wrong lengths and justify set; justify code 11; delay 3
      word(32'h40, 32'h09, 32'h1, 128'h2c, 9, 0, 32'h0034, 32'h0);
      word(32'h0, 32'h11, 32'h2001, 128'h0, 9, 0, 32'h8284, 32'h0);
      word(32'ha0, 32'h19, 32'h2001, 128'hd5, 9, 0, 32'h0008, 32'h0);
      word(32'h0, 32'h19, 32'h4001, 128'h55, 9, 0, 32'hfff8, 32'h0);
      word(32'h20, 32'h00, 32'h6001, 128'habc, 12, 0, 32'h0abc, 32'h0);
      word(32'h0, 32'h03, 32'h1, 128'h5a, 11, 0, 32'h005a, 32'h0);
      $display("options done");
      // dual phase: frame length, unexpected sync restart, ignored sync
      f = {8'h5a, 16'h1234, 16'hc3c3};
      word(32'h0, 32'h8141, 32'h31, {1'b0, f, 1'b0, f}, 82, 41, 32'hc3c3, 32'h0);
      check(irq_n, 0);
      rdk(8'h08, 32'h31);
      word(32'h0, 32'h8141, 32'h31, {1'b0, f[39:21], 1'b0, f}, 61, 20, 32'hc3c3, 32'h0);
      check(irq_n, 1);
      rdk(8'h08, 32'h39);
      apb(1'b1, 8'h08, 32'h31);
      rdk(8'h08, 32'h31);
      word(32'h0, 32'h8145, 32'h31, {1'b0, f[39:21], 1'b0, f}, 61, 20, 32'ha123, 32'h0);
      check(irq_n, 0);
      rdk(8'h08, 32'h31);
      $display("frames done");
      summarize();
   end
endmodule // test_sfr_rx_formatter
